// ===== src/gbxs_port_status.sv
// Status and event registers of a 1000BASE-X serial port on AXI4-Lite.
// How it works
// - Bits 15:14 of the port status give speed, 00 10M, 01 100M, 10 1000M.
// - Bit 13 of the port status shows duplex, one for full, zero for half.
// - Bit 11 is one when negotiation has completed or is disabled.
// - Bit 12 latches high on a received page and holds until it is read.
// - Bit 4 reads one while no energy is seen on the line, one from reset.
// - Bit 3 mirrors the transmit pause resolution given to the MAC.
// - Bit 2 mirrors the receive pause resolution given to the MAC.
// - A false carrier latches an event flag in the event status register.
// - A link going from down to up latches an event flag.
`timescale 1ns/1ps
`include "gbxs_defines.svh"
module gbxs_port_status #(
    parameter int ADDR_W = 20
) (
    // Clock, reset and clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Line side status from the port
    input wire gbxs_pkg::gbxs_line_t line,
    input wire gbxs_pkg::gbxs_pulse_t pulse,
    // AXI4-Lite write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq
);

    generate
        if (ADDR_W < `GBXS_MIN_ADDR_W || ADDR_W > 32) begin : g_bad
            $error("gbxs_port_status: ADDR_W must lie in 18..32");
        end
    endgenerate

    // -------------------------------------------------------------------
    // Address constants
    // -------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] A_MASK = ADDR_W'(`GBXS_MASK_ADDR);
    localparam logic [ADDR_W-1:0] A_EVT = ADDR_W'(`GBXS_EVT_ADDR);
    localparam logic [ADDR_W-1:0] A_SPEC = ADDR_W'(`GBXS_SPEC_ADDR);

    // -------------------------------------------------------------------
    // Line sampling
    // -------------------------------------------------------------------
    gbxs_pkg::gbxs_line_t line_q;
    logic primed_q;

    // Line status starts cleared, so energy reads absent until sampled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_q <= '0;
            primed_q <= 1'b0;
        end else if (ce) begin
            line_q <= line;
            primed_q <= 1'b1;
        end
    end

    // Change events are held off until a first sample has been taken.
    wire speed_chg = primed_q & (line.speed != line_q.speed);
    wire duplex_chg = primed_q & (line.duplex != line_q.duplex);
    wire an_done = primed_q & line.an_complete & ~line_q.an_complete;
    wire link_rise = primed_q & line.link_up & ~line_q.link_up;
    wire link_fall = primed_q & ~line.link_up & line_q.link_up;

    // -------------------------------------------------------------------
    // Write channel
    // -------------------------------------------------------------------
    gbxs_pkg::gbxs_wr_state_t wr_state_q;
    gbxs_pkg::gbxs_wr_state_t wr_state_d;
    logic aw_full_q;
    logic w_full_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [15:0] wdata_q;
    logic [1:0] wstrb_q;
    logic [1:0] bresp_q;

    wire in_collect = (wr_state_q == gbxs_pkg::GBXS_WR_COLLECT);
    assign s_axi_awready = ce & in_collect & ~aw_full_q;
    assign s_axi_wready = ce & in_collect & ~w_full_q;
    assign s_axi_bvalid = (wr_state_q == gbxs_pkg::GBXS_WR_RESP);
    assign s_axi_bresp = bresp_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire do_wr = ce & in_collect & aw_full_q & w_full_q;

    wire wr_mask = (awaddr_q == A_MASK);
    wire wr_evt = (awaddr_q == A_EVT);
    wire wr_spec = (awaddr_q == A_SPEC);
    wire wr_hit = wr_mask | wr_evt | wr_spec;
    wire [15:0] wr_lanes = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [15:0] wr_bits = wdata_q & wr_lanes;

    always_comb begin
        wr_state_d = wr_state_q;
        case (wr_state_q)
            gbxs_pkg::GBXS_WR_COLLECT: begin
                if (do_wr) begin
                    wr_state_d = gbxs_pkg::GBXS_WR_RESP;
                end
            end
            gbxs_pkg::GBXS_WR_RESP: begin
                if (ce && s_axi_bready) begin
                    wr_state_d = gbxs_pkg::GBXS_WR_COLLECT;
                end
            end
            default: begin
                wr_state_d = gbxs_pkg::GBXS_WR_COLLECT;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= gbxs_pkg::GBXS_WR_COLLECT;
        end else begin
            wr_state_q <= wr_state_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            awaddr_q <= '0;
        end else if (aw_take) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            wdata_q <= 16'h0000;
            wstrb_q <= 2'h0;
        end else if (w_take) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata[15:0];
            wstrb_q <= s_axi_wstrb[1:0];
        end else if (do_wr) begin
            w_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_q <= `GBXS_RESP_OKAY;
        end else if (do_wr) begin
            bresp_q <= wr_hit ? `GBXS_RESP_OKAY : `GBXS_RESP_SLVERR;
        end
    end

    // -------------------------------------------------------------------
    // Mask register
    // -------------------------------------------------------------------
    logic [15:0] mask_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= `GBXS_MASK_RST;
        end else if (do_wr && wr_mask) begin
            mask_q <= ((mask_q & ~wr_lanes) | wr_bits) & `GBXS_EVT_IMPL;
        end
    end

    // -------------------------------------------------------------------
    // Read channel
    // -------------------------------------------------------------------
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign s_axi_arready = ce & ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rd_mask = (s_axi_araddr == A_MASK);
    wire rd_evt = (s_axi_araddr == A_EVT);
    wire rd_spec = (s_axi_araddr == A_SPEC);
    wire rd_hit = rd_mask | rd_evt | rd_spec;

    // -------------------------------------------------------------------
    // Sticky flags
    // -------------------------------------------------------------------
    logic [15:0] evt_set;
    logic [15:0] evt_flags;
    logic page_flag;

    always_comb begin
        evt_set = 16'h0000;
        evt_set[`GBXS_EVT_SPEED_CHG] = speed_chg;
        evt_set[`GBXS_EVT_DUPLEX_CHG] = duplex_chg;
        evt_set[`GBXS_EVT_PAGE] = pulse.page_rx;
        evt_set[`GBXS_EVT_AN_DONE] = an_done;
        evt_set[`GBXS_EVT_LINK_DOWN] = link_fall;
        evt_set[`GBXS_EVT_LINK_UP] = link_rise;
        evt_set[`GBXS_EVT_SYMBOL] = pulse.symbol_err;
        evt_set[`GBXS_EVT_FALSE_CAR] = pulse.false_carrier;
    end

    // Event flags clear on a read of their register or on a write of one; the page flag clears only on a status read.
    wire [15:0] evt_rd_clr = (ar_take && rd_evt) ? 16'hFFFF : 16'h0000;
    wire [15:0] evt_w1c = (do_wr && wr_evt) ? wr_bits : 16'h0000;
    wire [15:0] evt_clr = evt_rd_clr | evt_w1c;
    wire page_clr = ar_take & rd_spec;

    gbxs_flag_latch #(
        .WIDTH(16)
    ) u_evt (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .set(evt_set),
        .clr(evt_clr),
        .flags(evt_flags)
    );

    gbxs_flag_latch #(
        .WIDTH(1)
    ) u_page (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .set(pulse.page_rx),
        .clr(page_clr),
        .flags(page_flag)
    );

    // -------------------------------------------------------------------
    // Port status word
    // -------------------------------------------------------------------
    logic [15:0] spec_word;

    // Pause bits feed only this word and drive no internal decision.
    always_comb begin
        spec_word = 16'h0000;
        spec_word[`GBXS_SPEC_SPEED_HI:`GBXS_SPEC_SPEED_LO] = line_q.speed;
        spec_word[`GBXS_SPEC_DUPLEX] = line_q.duplex;
        spec_word[`GBXS_SPEC_PAGE] = page_flag;
        spec_word[`GBXS_SPEC_RESOLVED] =
            ~line_q.an_enable | line_q.an_complete;
        spec_word[`GBXS_SPEC_LINK] = line_q.link_up;
        spec_word[`GBXS_SPEC_SYNC] = line_q.sync_ok;
        spec_word[`GBXS_SPEC_NO_ENERGY] = ~line_q.energy_present;
        spec_word[`GBXS_SPEC_TX_PAUSE] = line_q.tx_pause;
        spec_word[`GBXS_SPEC_RX_PAUSE] = line_q.rx_pause;
    end

    wire [15:0] rd_word = rd_spec ? spec_word :
                          rd_evt ? evt_flags :
                          rd_mask ? mask_q : 16'h0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `GBXS_RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= {16'h0000, rd_word};
                rresp_q <= rd_hit ? `GBXS_RESP_OKAY : `GBXS_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Interrupt
    // -------------------------------------------------------------------
    logic irq_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(evt_flags & mask_q);
        end
    end

    assign irq = irq_q;

endmodule // gbxs_port_status

// ===== src/gbxs_defines.svh
// Register offsets, field positions, reset values and bus codes.
`ifndef GBXS_DEFINES_SVH
`define GBXS_DEFINES_SVH

// -----------------------------------------------------------------------
// Register indices and byte addresses (byte address is four times index)
// -----------------------------------------------------------------------
`define GBXS_MASK_IDX 16'hA001
`define GBXS_EVT_IDX 16'hA002
`define GBXS_SPEC_IDX 16'hA003
`define GBXS_MASK_ADDR {`GBXS_MASK_IDX, 2'b00}
`define GBXS_EVT_ADDR {`GBXS_EVT_IDX, 2'b00}
`define GBXS_SPEC_ADDR {`GBXS_SPEC_IDX, 2'b00}
`define GBXS_MIN_ADDR_W 18

// -----------------------------------------------------------------------
// Port specific status fields
// -----------------------------------------------------------------------
`define GBXS_SPEC_SPEED_HI 15
`define GBXS_SPEC_SPEED_LO 14
`define GBXS_SPEC_DUPLEX 13
`define GBXS_SPEC_PAGE 12
`define GBXS_SPEC_RESOLVED 11
`define GBXS_SPEC_LINK 10
`define GBXS_SPEC_SYNC 5
`define GBXS_SPEC_NO_ENERGY 4
`define GBXS_SPEC_TX_PAUSE 3
`define GBXS_SPEC_RX_PAUSE 2
`define GBXS_SPEC_NO_ENERGY_RST 1'h1

// -----------------------------------------------------------------------
// Event status and mask fields
// -----------------------------------------------------------------------
`define GBXS_EVT_SPEED_CHG 14
`define GBXS_EVT_DUPLEX_CHG 13
`define GBXS_EVT_PAGE 12
`define GBXS_EVT_AN_DONE 11
`define GBXS_EVT_LINK_DOWN 10
`define GBXS_EVT_LINK_UP 9
`define GBXS_EVT_SYMBOL 8
`define GBXS_EVT_FALSE_CAR 7
`define GBXS_EVT_IMPL 16'h7F80
`define GBXS_EVT_RST 16'h0000
`define GBXS_MASK_RST 16'h0000

// -----------------------------------------------------------------------
// Bus response codes
// -----------------------------------------------------------------------
`define GBXS_RESP_OKAY 2'h0
`define GBXS_RESP_SLVERR 2'h2

`endif

// ===== src/gbxs_pkg.sv
// Types shared by the port status block.
package gbxs_pkg;

    typedef struct packed {
        logic [1:0] speed;
        logic duplex;
        logic an_enable;
        logic an_complete;
        logic link_up;
        logic sync_ok;
        logic energy_present;
        logic tx_pause;
        logic rx_pause;
    } gbxs_line_t;

    typedef struct packed {
        logic page_rx;
        logic symbol_err;
        logic false_carrier;
    } gbxs_pulse_t;

    typedef enum logic {
        GBXS_WR_COLLECT,
        GBXS_WR_RESP
    } gbxs_wr_state_t;

endpackage

// ===== src/gbxs_flag_latch.sv
// Bank of sticky flags in which a set always wins over a clear.
`timescale 1ns/1ps
module gbxs_flag_latch #(
    parameter int WIDTH = 16
) (
    // Clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Flag update
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] flags
);

    generate
        if (WIDTH < 1) begin : g_bad
            $error("gbxs_flag_latch: WIDTH must be at least one");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic flag_q;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flag_q <= 1'b0;
                end else if (ce) begin
                    flag_q <= set[i] | (flag_q & ~clr[i]);
                end
            end
            assign flags[i] = flag_q;
        end
    endgenerate

endmodule // gbxs_flag_latch

// ===== testbench/gbxs_props.sv
// Checker of read timing and port status fields.
`timescale 1ns/1ps
`include "gbxs_defines.svh"
module gbxs_props #(
    parameter int ADDR_W = 20
) (
    // Clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Line status
    input wire gbxs_pkg::gbxs_line_t line,
    // Read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    gbxs_pkg::gbxs_line_t line_q;
    logic ok_q;
    logic spec_rd;
    always_ff @(posedge aclk) begin
        line_q <= line;
        ok_q <= aresetn && ce;
    end
    // A status read taken while the line was steady and already sampled.
    assign spec_rd = s_axi_arvalid && s_axi_arready && ok_q &&
        line == line_q && s_axi_araddr == ADDR_W'(`GBXS_SPEC_ADDR);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read not answered");
    AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready && ce
        |=> !s_axi_rvalid) else $error("read data not released");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");
    AST_SPEED: assert property (spec_rd |=>
        s_axi_rdata[31:14] == {16'h0000, line_q.speed})
        else $error("speed field wrong");
    AST_DUPLEX: assert property (spec_rd |=>
        s_axi_rdata[13] == line_q.duplex) else $error("duplex wrong");
    AST_RESOLVED: assert property (spec_rd |=>
        s_axi_rdata[11] == (!line_q.an_enable || line_q.an_complete))
        else $error("resolved flag wrong");
    AST_ENERGY: assert property (spec_rd |=>
        s_axi_rdata[4] == !line_q.energy_present)
        else $error("energy status wrong");
    AST_PAUSE: assert property (spec_rd |=>
        s_axi_rdata[3:2] == {line_q.tx_pause, line_q.rx_pause})
        else $error("pause bits wrong");
    cover property (spec_rd && line.an_enable && !line.an_complete);
    cover property (spec_rd && !line.energy_present);
    cover property (s_axi_rvalid && s_axi_rdata[12]);
endmodule // gbxs_props
bind gbxs_port_status gbxs_props #(.ADDR_W(ADDR_W)) u_props (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .line(line),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// ===== testbench/gbxs_link_partner.sv
// Link partner model driving line status and event pulses.
`timescale 1ns/1ps
module gbxs_link_partner (
    // Clock
    input wire logic aclk,
    // Status toward the port
    output gbxs_pkg::gbxs_line_t line,
    output gbxs_pkg::gbxs_pulse_t pulse
);
    initial begin
        line = '0;
        pulse = '0;
    end
    task automatic set_line(input gbxs_pkg::gbxs_line_t l);
        @(posedge aclk);
        line <= l;
    endtask
    // Pulses last exactly one cycle, as a received event does.
    task automatic send(input gbxs_pkg::gbxs_pulse_t p);
        @(posedge aclk);
        pulse <= p;
        @(posedge aclk);
        pulse <= '0;
    endtask
endmodule // gbxs_link_partner

// ===== testbench/testbench.sv
// Self-checking bench for the port status block.
`timescale 1ns/1ps
`include "gbxs_defines.svh"
module testbench;
    localparam int AW = 20;
    localparam logic [AW-1:0] A_M = AW'(`GBXS_MASK_ADDR);
    localparam logic [AW-1:0] A_E = AW'(`GBXS_EVT_ADDR);
    localparam logic [AW-1:0] A_S = AW'(`GBXS_SPEC_ADDR);
    localparam logic [1:0] OK = `GBXS_RESP_OKAY;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    gbxs_pkg::gbxs_line_t line;
    gbxs_pkg::gbxs_pulse_t pulse;
    logic [AW-1:0] awaddr = '0;
    logic [AW-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic ce = 1'b1;
    logic bready = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [1:0] r;
    int bad_count = 0;
    int checks = 0;
    int evt_m = 0;
    gbxs_pkg::gbxs_line_t l;
    gbxs_pkg::gbxs_line_t prev = '0;

    gbxs_link_partner u_lp (.aclk(aclk), .line(line), .pulse(pulse));
    gbxs_port_status #(.ADDR_W(AW)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .line(line),
        .pulse(pulse), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq)
    );

    initial begin
        forever #5 aclk = ~aclk;
    end

    task automatic final_report();
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tick(inout int n);
        n++;
        if (n > 50) begin
            chk(32'h0, 32'h1);
            final_report();
        end
    endtask
    // Ready and valid are judged at the falling edge, where they are settled.
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        int n;
        logic aw_h, w_h, done;
        logic [1:0] b;
        n = 0;
        done = 1'b0;
        b = 2'h0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            aw_h = awvalid && awready;
            w_h = wvalid && wready;
            done = bvalid;
            b = bresp;
            @(posedge aclk);
            if (aw_h) awvalid <= 1'b0;
            if (w_h) wvalid <= 1'b0;
            tick(n);
        end
        bready <= 1'b0;
        chk({30'h0, b}, {30'h0, er});
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        logic ar_h, done;
        n = 0;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        // Ready for the answer stays up between reads.
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ar_h = arvalid && arready;
            done = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_h) arvalid <= 1'b0;
            tick(n);
        end
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    function automatic logic [31:0] spec(gbxs_pkg::gbxs_line_t x,
                                         logic pg);
        return {16'h0000, x.speed, x.duplex, pg,
                (!x.an_enable || x.an_complete), x.link_up, 4'h0,
                x.sync_ok, !x.energy_present, x.tx_pause, x.rx_pause, 2'h0};
    endfunction
    // Event model: a change of speed, duplex or link, or negotiation completing, latches its flag.
    task automatic settle(input gbxs_pkg::gbxs_line_t x);
        if (x.speed != prev.speed) evt_m |= 1 << `GBXS_EVT_SPEED_CHG;
        if (x.duplex != prev.duplex) evt_m |= 1 << `GBXS_EVT_DUPLEX_CHG;
        if (x.an_complete && !prev.an_complete)
            evt_m |= 1 << `GBXS_EVT_AN_DONE;
        if (!x.link_up && prev.link_up) evt_m |= 1 << `GBXS_EVT_LINK_DOWN;
        if (x.link_up && !prev.link_up) evt_m |= 1 << `GBXS_EVT_LINK_UP;
        prev = x;
        u_lp.set_line(x);
        repeat (2) @(posedge aclk);
    endtask
    // A read of the event register returns the model and clears it.
    task automatic rd_evt();
        rd(A_E, evt_m, OK);
        evt_m = 0;
    endtask

    initial begin
        d = $urandom(35276);
        l = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(A_S, spec(l, 1'b0), OK);
        rd(A_E, 32'h0, OK);
        rd(A_M, 32'h0, OK);
        for (int i = 0; i < 10; i++) begin
            l = gbxs_pkg::gbxs_line_t'(10'($urandom));
            if (l.speed == 2'h3) l.speed = 2'h2;
            settle(l);
            rd(A_S, spec(l, 1'b0), OK);
        end
        rd_evt();
        l.tx_pause = !l.tx_pause;
        l.rx_pause = !l.rx_pause;
        settle(l);
        rd_evt();
        u_lp.send(3'b100);
        evt_m |= 1 << `GBXS_EVT_PAGE;
        repeat (2) @(posedge aclk);
        rd(A_S, spec(l, 1'b1), OK);
        rd(A_S, spec(l, 1'b0), OK);
        rd_evt();
        u_lp.send(3'b010);
        evt_m |= 1 << `GBXS_EVT_SYMBOL;
        u_lp.send(3'b001);
        evt_m |= 1 << `GBXS_EVT_FALSE_CAR;
        repeat (2) @(posedge aclk);
        rd_evt();
        rd_evt();
        l.link_up = 1'b0;
        settle(l);
        rd_evt();
        l.link_up = 1'b1;
        settle(l);
        rd_evt();
        wr(A_M, 32'h0080, OK);
        rd(A_M, 32'h0080, OK);
        u_lp.send(3'b001);
        evt_m |= 1 << `GBXS_EVT_FALSE_CAR;
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(A_E, 32'h0080, OK);
        evt_m &= ~(1 << `GBXS_EVT_FALSE_CAR);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rd_evt();
        // A pulse while the clock enable is low must leave no flag.
        ce <= 1'b0;
        u_lp.send(3'b001);
        repeat (2) @(posedge aclk);
        ce <= 1'b1;
        rd_evt();
        wr(A_S, 32'hFFFF, OK);
        rd(A_S, spec(l, 1'b0), OK);
        wr(20'h00000, 32'hFFFF, `GBXS_RESP_SLVERR);
        rd(20'h00000, 32'h0, `GBXS_RESP_SLVERR);
        wstrb <= 4'h2;
        wr(A_M, 32'hFFFF, OK);
        rd(A_M, 32'h7F80, OK);
        final_report();
    end
endmodule // testbench
